// file: core/tpu_chan.sv
// Purpose: one timer/pwm channel with shared counter and clock select
// Assumes: AXI4-Lite master, all inputs synchronous except clock pins
// Notes:   prescaler omitted; one counter step per selected clock tick
//
// Notes on behaviour
// - edge/level 00 releases the pin to general purpose i/o
// - capture mode: 01 rising, 10 falling, 11 either edge
// - compare: 00 flag only, 01 toggle, 10 low, 11 high
// - edge pwm: 10 high-true cleared at compare, x1 low-true set
// - center pwm: same polarity choices on up-count compare
// - value register clears to zero; holds capture or compare
// - capture mode read of a byte latches both until other read
// - status/control write resets read and write latching always
// - value writes ignored in capture mode
// - debug halt freezes read latches unless status/control written
// - debug halt reads return live value, not buffer
// - writes buffered; no clock selected moves both at second byte
// - compare with clock: transfer on next counter change
// - pwm with clock: transfer when counter steps top-1 to top
// - debug halt writes go straight into the value register
// - debug halt writes leave a partial write sequence intact
// - center select forces center pwm and up/down counting
// - clock select: none, bus, fixed system clock, external
// - clock select resets to none; none stops without clearing
// - fixed clock synchronised only while a loop is engaged
// - external clock always synchronised; at most bus/4
// - flag clears by read-with-flag then write 0; new event wins
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`include "tpu_chan_defs.svh"

module tpu_chan
	import tpu_chan_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              debug_halt_mode,
	input  wire logic              loop_engaged,
	input  wire logic              fixed_clk,
	input  wire logic              ext_clk,
	input  wire logic              chan_pin_in,
	output logic                   chan_pin_out,
	output logic                   chan_pin_oe
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic              awready_ff, wready_ff, bvalid_ff, arready_ff;
	logic              rvalid_ff, aw_held_ff, w_held_ff;
	logic [1:0]        bresp_ff, rresp_ff;
	logic [31:0]       rdata_ff, wdata_ff;
	logic [3:0]        wstrb_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic              center_aligned_select_ff;
	clk_src_t          clk_sel_ff;
	logic [15:0]       modulus_ff, cnt_ff, value_ff, wbuf_ff, rdbuf_ff;
	logic              down_ff, cnt_chg_ff;
	logic              flag_ff, arm_ff, ie_ff;
	logic [1:0]        mode_sel_ff, edge_level_ff;
	logic              got_hi_ff, got_lo_ff, pend_ff;
	logic              rd_latched_ff, rd_first_hi_ff;
	logic              fix_s1_ff, fix_s2_ff, fix_s3_ff;
	logic              ext_s1_ff, ext_s2_ff, ext_s3_ff;
	logic              pin_prev_ff, pin_out_ff, pin_oe_ff;

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign chan_pin_out  = pin_out_ff;
	assign chan_pin_oe   = pin_oe_ff;

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	logic        wr_fire, rd_fire, byte_ok, mapped_wr, mapped_rd;
	logic        tsc_wr, mod_wr, cnt_wr, csc_wr, vhi_wr, vlo_wr, val_wr;
	logic        csc_rd, vhi_rd, vlo_rd, dbg, tick, tick_src;
	logic        is_cap, is_pwm, match_evt, cap_evt, chan_evt, rise, fall;
	logic [15:0] top, nxt_wval;
	logic [7:0]  wbyte;
	logic [31:0] nxt_rdata;
	chan_mode_t  mode;

	assign wr_fire  = ce & aw_held_ff & w_held_ff & ~bvalid_ff;
	assign rd_fire  = ce & s_axi_arvalid & arready_ff;
	assign byte_ok  = wstrb_ff[0];
	assign wbyte    = wdata_ff[7:0];
	assign tsc_wr   = wr_fire & byte_ok & (awaddr_ff == `OFS_TIMER_SC);
	assign mod_wr   = wr_fire & (awaddr_ff == `OFS_MODULUS);
	assign cnt_wr   = wr_fire & (awaddr_ff == `OFS_COUNTER);
	assign csc_wr   = wr_fire & byte_ok & (awaddr_ff == `OFS_CHAN_SC);
	assign vhi_wr   = wr_fire & byte_ok & (awaddr_ff == `OFS_VAL_HI);
	assign vlo_wr   = wr_fire & byte_ok & (awaddr_ff == `OFS_VAL_LO);
	assign val_wr   = vhi_wr | vlo_wr;
	assign mapped_wr = (awaddr_ff == `OFS_TIMER_SC) |
		(awaddr_ff == `OFS_MODULUS) | (awaddr_ff == `OFS_COUNTER) |
		(awaddr_ff == `OFS_CHAN_SC) | (awaddr_ff == `OFS_VAL_HI) |
		(awaddr_ff == `OFS_VAL_LO);
	assign csc_rd   = rd_fire & (s_axi_araddr == `OFS_CHAN_SC);
	assign vhi_rd   = rd_fire & (s_axi_araddr == `OFS_VAL_HI);
	assign vlo_rd   = rd_fire & (s_axi_araddr == `OFS_VAL_LO);
	assign dbg      = debug_halt_mode;
	assign nxt_wval = vhi_wr ? {wbyte, wbuf_ff[7:0]} : {wbuf_ff[15:8], wbyte};
	assign top      = (modulus_ff == 16'h0000) ? `COUNT_FREE_TOP : modulus_ff;

	// center select overrides the per-channel mode bits
	always_comb begin
		if (center_aligned_select_ff) begin
			mode = MODE_CENTER_ALIGNED_PWM;
		end else begin
			case (mode_sel_ff)
				2'b00:   mode = MODE_CAPTURE;
				2'b01:   mode = MODE_COMPARE;
				default: mode = MODE_EDGE_ALIGNED_PWM;
			endcase
		end
	end
	assign is_cap = (mode == MODE_CAPTURE);
	assign is_pwm = (mode == MODE_EDGE_ALIGNED_PWM) | (mode == MODE_CENTER_ALIGNED_PWM);

	// ------------------------------------------------------------------
	// clock source and synchronisers
	// ------------------------------------------------------------------
	// edges are taken between stage two and three, never on stage one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{fix_s1_ff, fix_s2_ff, fix_s3_ff} <= 3'h0;
			{ext_s1_ff, ext_s2_ff, ext_s3_ff} <= 3'h0;
		end else if (ce) begin
			{fix_s1_ff, fix_s2_ff, fix_s3_ff} <= {fixed_clk, fix_s1_ff, fix_s2_ff};
			{ext_s1_ff, ext_s2_ff, ext_s3_ff} <= {ext_clk, ext_s1_ff, ext_s2_ff};
		end
	end

	always_comb begin
		case (clk_sel_ff)
			CLK_NONE:  tick_src = 1'b0;
			CLK_BUS:   tick_src = 1'b1;
			CLK_FIXED: tick_src = loop_engaged ? (fix_s2_ff & ~fix_s3_ff) : 1'b1;
			CLK_EXT:   tick_src = ext_s2_ff & ~ext_s3_ff;
			default:   tick_src = 1'b0;
		endcase
	end
	// counter is frozen while halted
	assign tick = ce & tick_src & ~dbg;

	// ------------------------------------------------------------------
	// counter
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff     <= 16'h0000;
			down_ff    <= 1'b0;
			cnt_chg_ff <= 1'b0;
		end else if (ce) begin
			cnt_chg_ff <= tick & ~cnt_wr;
			if (cnt_wr) begin
				cnt_ff  <= 16'h0000;
				down_ff <= 1'b0;
			end else if (tick && center_aligned_select_ff) begin
				if (!down_ff && cnt_ff >= top) begin
					down_ff <= 1'b1;
					cnt_ff  <= cnt_ff - 16'h0001;
				end else if (down_ff && cnt_ff == 16'h0000) begin
					down_ff <= 1'b0;
					cnt_ff  <= 16'h0001;
				end else begin
					cnt_ff <= down_ff ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
				end
			end else if (tick) begin
				down_ff <= 1'b0;
				cnt_ff  <= (cnt_ff == top) ? 16'h0000 : cnt_ff + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			center_aligned_select_ff <= 1'b0;
			clk_sel_ff               <= clk_src_t'(`CLKS_RESET);
			modulus_ff               <= 16'h0000;
			ie_ff                    <= 1'b0;
			mode_sel_ff              <= 2'h0;
			edge_level_ff            <= 2'h0;
		end else if (ce) begin
			if (tsc_wr) begin
				center_aligned_select_ff <= wbyte[`TSC_CENTER_ALIGNED_SELECT_BIT];
				// selecting none leaves counter and registers as they are
				clk_sel_ff <= clk_src_t'(wbyte[`TSC_CLKS_HI:`TSC_CLKS_LO]);
			end
			if (mod_wr) begin
				if (wstrb_ff[0]) modulus_ff[7:0]  <= wdata_ff[7:0];
				if (wstrb_ff[1]) modulus_ff[15:8] <= wdata_ff[15:8];
			end
			if (csc_wr) begin
				ie_ff         <= wbyte[`CSC_IE_BIT];
				mode_sel_ff   <= wbyte[`CSC_MS_HI:`CSC_MS_LO];
				edge_level_ff <= wbyte[`CSC_ELS_HI:`CSC_ELS_LO];
			end
		end
	end

	// ------------------------------------------------------------------
	// channel events and flag
	// ------------------------------------------------------------------
	assign rise      = chan_pin_in & ~pin_prev_ff;
	assign fall      = ~chan_pin_in & pin_prev_ff;
	assign match_evt = cnt_chg_ff & (cnt_ff == value_ff);
	assign cap_evt   = ce & is_cap & (
		((edge_level_ff == 2'b01) & rise) |
		((edge_level_ff == 2'b10) & fall) |
		((edge_level_ff == 2'b11) & (rise | fall)));
	assign chan_evt  = cap_evt | (ce & ~is_cap & match_evt);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_ff     <= 1'b0;
			arm_ff      <= 1'b0;
			pin_prev_ff <= 1'b0;
		end else if (ce) begin
			pin_prev_ff <= chan_pin_in;
			// a new event restarts the clear sequence and wins
			if (chan_evt) begin
				flag_ff <= 1'b1;
				arm_ff  <= 1'b0;
			end else if (csc_wr && !wbyte[`CSC_FLAG_BIT] && arm_ff) begin
				flag_ff <= 1'b0;
				arm_ff  <= 1'b0;
			end else if (csc_rd && flag_ff) begin
				arm_ff <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out_ff <= 1'b0;
			pin_oe_ff  <= 1'b0;
		end else if (ce) begin
			pin_oe_ff <= (edge_level_ff != 2'b00) & ~is_cap;
			case (mode)
				MODE_COMPARE: begin
					if (match_evt) begin
						case (edge_level_ff)
							2'b01:   pin_out_ff <= ~pin_out_ff;
							2'b10:   pin_out_ff <= 1'b0;
							2'b11:   pin_out_ff <= 1'b1;
							default: pin_out_ff <= pin_out_ff;
						endcase
					end
				end
				MODE_EDGE_ALIGNED_PWM: begin
					// match after wrap wins, giving a true 0% duty
					if (match_evt) begin
						pin_out_ff <= edge_level_ff[0];
					end else if (cnt_chg_ff && cnt_ff == 16'h0000) begin
						pin_out_ff <= ~edge_level_ff[0];
					end
				end
				MODE_CENTER_ALIGNED_PWM: begin
					if (match_evt) begin
						pin_out_ff <= down_ff ? ~edge_level_ff[0] : edge_level_ff[0];
					end
				end
				default: pin_out_ff <= pin_out_ff;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// value register and write coherency
	// ------------------------------------------------------------------
	// state is per instance, so every channel has its own buffers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value_ff  <= `VALUE_RESET;
			wbuf_ff   <= `VALUE_RESET;
			got_hi_ff <= 1'b0;
			got_lo_ff <= 1'b0;
			pend_ff   <= 1'b0;
		end else if (ce) begin
			if (cap_evt) begin
				value_ff <= cnt_ff;
			end
			// center mode passes top-1 twice; only the upward step counts
			if (pend_ff && tick && !is_cap && (!is_pwm ||
			    (cnt_ff == top - 16'h0001 && !down_ff))) begin
				value_ff <= wbuf_ff;
				pend_ff  <= 1'b0;
			end
			if (csc_wr) begin
				got_hi_ff <= 1'b0;
				got_lo_ff <= 1'b0;
				pend_ff   <= 1'b0;
			end else if (val_wr && !is_cap) begin
				if (dbg) begin
					if (vhi_wr) value_ff[15:8] <= wbyte;
					else        value_ff[7:0]  <= wbyte;
				end else if ((vhi_wr && got_lo_ff) || (vlo_wr && got_hi_ff)) begin
					wbuf_ff   <= nxt_wval;
					got_hi_ff <= 1'b0;
					got_lo_ff <= 1'b0;
					if (clk_sel_ff == CLK_NONE) begin
						value_ff <= nxt_wval;
						pend_ff  <= 1'b0;
					end else begin
						pend_ff <= 1'b1;
					end
				end else begin
					wbuf_ff <= nxt_wval;
					if (vhi_wr) got_hi_ff <= 1'b1;
					else        got_lo_ff <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// read coherency
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdbuf_ff       <= 16'h0000;
			rd_latched_ff  <= 1'b0;
			rd_first_hi_ff <= 1'b0;
		end else if (ce) begin
			if (csc_wr) begin
				rd_latched_ff <= 1'b0;
			end else if ((vhi_rd || vlo_rd) && is_cap && !dbg) begin
				if (!rd_latched_ff) begin
					rdbuf_ff       <= value_ff;
					rd_latched_ff  <= 1'b1;
					rd_first_hi_ff <= vhi_rd;
				end else if (vhi_rd != rd_first_hi_ff) begin
					rd_latched_ff <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------------
	logic use_rdbuf;
	assign use_rdbuf = is_cap & rd_latched_ff & ~dbg;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (s_axi_araddr)
			`OFS_TIMER_SC: begin
				nxt_rdata[`TSC_CENTER_ALIGNED_SELECT_BIT] = center_aligned_select_ff;
				nxt_rdata[`TSC_CLKS_HI:`TSC_CLKS_LO] = clk_sel_ff;
			end
			`OFS_MODULUS: nxt_rdata[15:0] = modulus_ff;
			`OFS_COUNTER: nxt_rdata[15:0] = cnt_ff;
			`OFS_CHAN_SC: begin
				nxt_rdata[`CSC_FLAG_BIT] = flag_ff;
				nxt_rdata[`CSC_IE_BIT]   = ie_ff;
				nxt_rdata[`CSC_MS_HI:`CSC_MS_LO]   = mode_sel_ff;
				nxt_rdata[`CSC_ELS_HI:`CSC_ELS_LO] = edge_level_ff;
			end
			`OFS_VAL_HI: nxt_rdata[7:0] = use_rdbuf ? rdbuf_ff[15:8] : value_ff[15:8];
			`OFS_VAL_LO: nxt_rdata[7:0] = use_rdbuf ? rdbuf_ff[7:0] : value_ff[7:0];
			default: nxt_rdata = 32'h0000_0000;
		endcase
		mapped_rd = (s_axi_araddr == `OFS_TIMER_SC) |
			(s_axi_araddr == `OFS_MODULUS) | (s_axi_araddr == `OFS_COUNTER) |
			(s_axi_araddr == `OFS_CHAN_SC) | (s_axi_araddr == `OFS_VAL_HI) |
			(s_axi_araddr == `OFS_VAL_LO);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && awready_ff) begin
				awaddr_ff  <= s_axi_awaddr;
				aw_held_ff <= 1'b1;
				awready_ff <= 1'b0;
			end else if (bvalid_ff && s_axi_bready) begin
				aw_held_ff <= 1'b0;
				awready_ff <= 1'b1;
			end
			if (s_axi_wvalid && wready_ff) begin
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
				w_held_ff <= 1'b1;
				wready_ff <= 1'b0;
			end else if (bvalid_ff && s_axi_bready) begin
				w_held_ff <= 1'b0;
				wready_ff <= 1'b1;
			end
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= mapped_wr ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= `RESP_OKAY;
		end else if (ce) begin
			if (rd_fire) begin
				rdata_ff   <= nxt_rdata;
				rresp_ff   <= mapped_rd ? `RESP_OKAY : `RESP_SLVERR;
				rvalid_ff  <= 1'b1;
				arready_ff <= 1'b0;
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_first_read;
		ce && (vhi_rd || vlo_rd) && is_cap && !dbg && !rd_latched_ff && !csc_wr;
	endsequence

	a_gpio_release: assert property (
		ce && edge_level_ff == 2'b00 |=> !pin_oe_ff)
		else $error("pin not released");
	a_capture_load: assert property (
		cap_evt |=> value_ff == $past(cnt_ff))
		else $error("capture lost");
	a_compare_toggle: assert property (
		ce && mode == MODE_COMPARE && edge_level_ff == 2'b01 && match_evt
		|=> pin_out_ff != $past(pin_out_ff))
		else $error("no toggle");
	a_read_latch: assert property (
		s_first_read |=> rd_latched_ff && rdbuf_ff == $past(value_ff))
		else $error("read not latched");
	a_csc_unlatch: assert property (
		csc_wr |=> !rd_latched_ff && !got_hi_ff && !got_lo_ff && !pend_ff)
		else $error("latch kept");
	a_capture_nowrite: assert property (
		ce && is_cap && val_wr && !cap_evt |=> $stable(value_ff))
		else $error("capture write taken");
	a_halt_freeze: assert property (
		ce && dbg && !csc_wr |=> $stable(rd_latched_ff))
		else $error("latch moved in halt");
	a_direct_load: assert property (
		ce && !dbg && !is_cap && !csc_wr && clk_sel_ff == CLK_NONE &&
		((vhi_wr && got_lo_ff) || (vlo_wr && got_hi_ff))
		|=> value_ff == $past(nxt_wval))
		else $error("no direct load");
	a_pwm_hold: assert property (
		ce && is_pwm && pend_ff && tick && !val_wr && !csc_wr &&
		(cnt_ff != top - 16'h0001 || down_ff) |=> $stable(value_ff))
		else $error("early pwm transfer");
	a_halt_write: assert property (
		ce && dbg && vlo_wr && !is_cap && !csc_wr
		|=> value_ff[7:0] == $past(wbyte) && $stable(got_hi_ff))
		else $error("halt write wrong");
	a_flag_set_wins: assert property (
		chan_evt |=> flag_ff ##1 (flag_ff || !ce || $past(csc_wr)))
		else $error("event lost");

endmodule : tpu_chan

// file: core/tpu_chan_defs.svh
// Purpose: offsets, field positions, reset values of the timer channel
// Assumes: byte-wide registers sit in the low bits of aligned words
// Notes:   included by its bare name
`ifndef TPU_CHAN_DEFS_SVH
`define TPU_CHAN_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_TIMER_SC      8'h00
`define OFS_MODULUS       8'h04
`define OFS_COUNTER       8'h08
`define OFS_CHAN_SC       8'h0c
`define OFS_VAL_HI        8'h10
`define OFS_VAL_LO        8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TSC_CENTER_ALIGNED_SELECT_BIT     5
`define TSC_CLKS_HI       4
`define TSC_CLKS_LO       3
`define CSC_FLAG_BIT      7
`define CSC_IE_BIT        6
`define CSC_MS_HI         5
`define CSC_MS_LO         4
`define CSC_ELS_HI        3
`define CSC_ELS_LO        2

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define CLKS_RESET        2'h0
`define VALUE_RESET       16'h0000
`define COUNT_FREE_TOP    16'hffff
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// file: core/tpu_chan_pkg.sv
// Purpose: types shared by the timer channel
// Assumes: nothing
// Notes:   codes written out in binary
package tpu_chan_pkg;
	typedef enum logic [1:0] {
		MODE_CAPTURE = 2'b00,
		MODE_COMPARE = 2'b01,
		MODE_EDGE_ALIGNED_PWM    = 2'b10,
		MODE_CENTER_ALIGNED_PWM    = 2'b11
	} chan_mode_t;

	typedef enum logic [1:0] {
		CLK_NONE  = 2'b00,
		CLK_BUS   = 2'b01,
		CLK_FIXED = 2'b10,
		CLK_EXT   = 2'b11
	} clk_src_t;
endpackage : tpu_chan_pkg

// file: tb/tpu_chan_pins.sv
// Purpose: pin-side stand-in making the fixed and external clock pins
// Assumes: external clock no faster than a quarter of aclk
// Notes:   both run free, phase unrelated to aclk
`timescale 1ns/10ps
module tpu_chan_pins (
	output logic fixed_clk,
	output logic ext_clk
);
	initial begin
		fixed_clk = 1'b0;
		#13;
		forever #56 fixed_clk = ~fixed_clk;
	end
	// 160 ns period: a quarter of the bus rate, never faster
	// own pin, so channel pin timing stays free of it
	initial begin
		ext_clk = 1'b0;
		#29;
		forever #80 ext_clk = ~ext_clk;
	end
endmodule : tpu_chan_pins

// file: tb/timer_channel_mode_and_value_coherency_tb_top.sv
// Purpose: self-checking bench for one timer channel
// Assumes: byte registers in low bits of aligned words
// Notes:   seed fixed, so random values repeat run to run
`timescale 1ns/10ps
`include "tpu_chan_defs.svh"
module timer_channel_mode_and_value_coherency_tb_top;
	logic        aclk, aresetn, awvalid, wvalid, arvalid, halt, pin, lock;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d, e;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        pin_out, pin_oe, fixed_clk, ext_clk;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] c1, v;
	int          bad_count = 0, compares = 0, cyc = 0, seed, t1;

	tpu_chan dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .debug_halt_mode(halt),
		.loop_engaged(lock), .fixed_clk(fixed_clk), .ext_clk(ext_clk),
		.chan_pin_in(pin), .chan_pin_out(pin_out), .chan_pin_oe(pin_oe));
	tpu_chan_pins pins (.fixed_clk(fixed_clk), .ext_clk(ext_clk));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// bus tasks and comparisons
	// ----------------------------------------------------------------
	task wrap_up;
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			wrap_up;
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch %0t read %h expected %h", $time, g, x);
		end
	endtask : chk

	task chk_pin(input logic g, input logic x);
		compares++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch %0t pin %b expected %b", $time, g, x);
		end
	endtask : chk_pin

	// bready/rready stay high, so only the request side moves
	task wr(input logic [7:0] a, input logic [31:0] x);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		awaddr <= a;
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge aclk);
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!dd && wready) begin
				dd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] x,
		output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		x = rdata;
		rs = rresp;
	endtask : rd

	task rv(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] g;
		logic [1:0] s;
		rd(a, g, s);
		chk(g, x);
	endtask : rv

	function automatic logic [31:0] csc(input logic [1:0] m,
		input logic [1:0] s);
		return {26'h0, m, s, 2'b00};
	endfunction : csc

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'hfddd;
		{aresetn, awvalid, wvalid, arvalid, halt, pin, lock} = 7'h0;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rv(`OFS_VAL_HI, 32'h0);
		rv(`OFS_VAL_LO, 32'h0);
		rv(`OFS_TIMER_SC, 32'h0);
		rd(8'hfc, d, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		wr(8'hfc, 32'h0);
		chk({30'h0, bresp}, {30'h0, `RESP_SLVERR});
		wr(`OFS_CHAN_SC, csc(2'b01, 2'b00));
		v = 16'h0;
		for (int i = 0; i < 4; i++) begin
			e = $random(seed);
			wr(i[0] ? `OFS_VAL_LO : `OFS_VAL_HI, i[0] ? e[7:0] : e[15:8]);
			rv(`OFS_VAL_LO, {24'h0, v[7:0]});
			wr(i[0] ? `OFS_VAL_HI : `OFS_VAL_LO, i[0] ? e[15:8] : e[7:0]);
			v = e[15:0];
			rv(`OFS_VAL_HI, {24'h0, v[15:8]});
			rv(`OFS_VAL_LO, {24'h0, v[7:0]});
		end
		wr(`OFS_CHAN_SC, csc(2'b00, 2'b01));
		wr(`OFS_VAL_HI, 32'h5a);
		wr(`OFS_VAL_LO, 32'ha5);
		rv(`OFS_VAL_HI, {24'h0, v[15:8]});
		rv(`OFS_VAL_LO, {24'h0, v[7:0]});
		// two rising edges a known distance apart; halt between reads
		wr(`OFS_TIMER_SC, 32'h08);
		pin <= 1'b1;
		t1 = cyc;
		repeat (5) @(posedge aclk);
		rd(`OFS_VAL_LO, e, r);
		pin <= 1'b0;
		repeat (300) @(posedge aclk);
		pin <= 1'b1;
		t1 = cyc - t1;
		repeat (5) @(posedge aclk);
		halt <= 1'b1;
		@(posedge aclk);
		rd(`OFS_VAL_HI, d, r);
		v[15:8] = d[7:0];
		rd(`OFS_VAL_LO, d, r);
		v[7:0] = d[7:0];
		halt <= 1'b0;
		rd(`OFS_VAL_HI, d, r);
		c1 = {d[7:0], e[7:0]} + t1[15:0];
		chk({16'h0, c1}, {16'h0, v});
		for (int i = 0; i < 3; i++) begin
			wr(`OFS_CHAN_SC, csc(2'b01, 2'b11 - i[1:0]));
			wr(`OFS_VAL_HI, 32'h0);
			wr(`OFS_VAL_LO, 32'h20);
			wr(`OFS_COUNTER, 32'h0);
			repeat (60) @(posedge aclk);
			chk_pin(pin_out, i != 1);
			chk_pin(pin_oe, 1'b1);
		end
		wr(`OFS_CHAN_SC, csc(2'b01, 2'b00));
		repeat (2) @(posedge aclk);
		chk_pin(pin_oe, 1'b0);
		wr(`OFS_TIMER_SC, 32'h0);
		rd(`OFS_COUNTER, d, r);
		repeat (10) @(posedge aclk);
		rv(`OFS_COUNTER, d);
		rv(`OFS_CHAN_SC, 32'h90);
		wr(`OFS_CHAN_SC, 32'h10);
		rv(`OFS_CHAN_SC, 32'h10);
		// fixed clock through the loop path, then the external pin
		lock <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			wr(`OFS_TIMER_SC, i[0] ? 32'h18 : 32'h10);
			wr(`OFS_COUNTER, 32'h0);
			repeat (400) @(posedge aclk);
			wr(`OFS_TIMER_SC, 32'h0);
			rd(`OFS_COUNTER, d, r);
			// about 403 cycles: 112 ns and 160 ns source periods
			t1 = i[0] ? 101 : 144;
			c1 = d[15:0] - t1[15:0];
			// from five ticks below to four ticks above the expected count
			chk({31'h0, c1 + 16'h5 < 16'ha}, 32'h1);
		end
		wr(`OFS_VAL_HI, 32'haa);
		halt <= 1'b1;
		wr(`OFS_VAL_LO, 32'h11);
		rv(`OFS_VAL_LO, 32'h11);
		rv(`OFS_VAL_HI, 32'h00);
		halt <= 1'b0;
		wr(`OFS_VAL_LO, 32'h22);
		rv(`OFS_VAL_HI, 32'haa);
		rv(`OFS_VAL_LO, 32'h22);
		// edge pwm, low-true; new value waits for the top-1 to top step
		wr(`OFS_CHAN_SC, csc(2'b10, 2'b01));
		wr(`OFS_MODULUS, 32'h3f);
		wr(`OFS_COUNTER, 32'h0);
		wr(`OFS_VAL_HI, 32'h0);
		wr(`OFS_VAL_LO, 32'h0);
		wr(`OFS_TIMER_SC, 32'h08);
		wr(`OFS_VAL_HI, 32'h0);
		wr(`OFS_VAL_LO, 32'h50);
		rv(`OFS_VAL_LO, 32'h0);
		repeat (80) @(posedge aclk);
		rv(`OFS_VAL_LO, 32'h50);
		// value above top: no compare, pin stays at the wrap level
		chk_pin(pin_out, 1'b0);
		wrap_up;
	end
endmodule : timer_channel_mode_and_value_coherency_tb_top
